// >>> logic/flash_host.sv
// Notes on behaviour
// - bus state from ce, oe, we
// - commands sent as ordinary write cycles
// - inside otp, ctrl writes with pwdata above OTP_CUST_HI are refused; addr_q is not checked
// - protect target chosen by block_select_address
// - protect writes use id voltage on reset
// - id codes readable by command sequence
//
// Chosen here: the APB slave port and the register addresses.
`default_nettype none
module flash_host
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // flash pins
  output flash_host_pkg::flash_bus_t fbus,
  output flash_host_pkg::flash_ctl_t fctl,
  input  wire logic [15:0]           dq_in,
  input  wire logic                  ready_busy_output
);
  import flash_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: flash is clockless, so its outputs are async here
  logic [15:0] dq_s1_q, dq_s2_q;
  logic        rb_s1_q, rb_s2_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_output;
      rb_s2_q <= rb_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SETUP = 3'b001,
    S_PULSE = 3'b010,
    S_RDWT  = 3'b011,
    S_POLL  = 3'b100,
    S_GAP   = 3'b101
  } st_t;

  st_t         st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [2:0]  step_q, step_d;
  op_t         op_q, op_d;
  logic [20:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d;
  logic [15:0] rdat_q, rdat_d;
  logic [15:0] last_q, last_d;
  logic        err_q, err_d;
  logic        otp_q, otp_d;
  logic [4:0]  pins_q, pins_d;
  flash_bus_t  bus_q, bus_d;
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d;
  logic        seq_last;
  logic [20:0] seq_a;
  logic [15:0] seq_dat;
  logic        seq_rd;
  logic        busy;
  logic        acc_w, acc_r;

  assign busy  = (st_q != S_IDLE);
  assign acc_w = psel && penable && pwrite && !pready;
  assign acc_r = psel && penable && !pwrite && !pready;

  // cycle table per operation; commands are plain write cycles
  always_comb begin
    seq_a    = UA1;
    seq_dat  = UD1;
    seq_rd   = 1'b0;
    seq_last = 1'b0;
    unique case (op_q)
      OP_READ, OP_AUTOID: begin
        seq_a    = addr_q;   // a9 at id voltage gives codes
        seq_rd   = 1'b1;
        seq_last = 1'b1;
      end
      OP_RESET: begin
        seq_dat  = CMD_RESET;
        seq_last = 1'b1;
      end
      OP_RAW_WR, OP_PROT: begin
        // protect uses block_select_address with a6/a1/a0 from sw
        seq_a    = addr_q;
        seq_dat  = wdat_q;
        seq_last = 1'b1;
      end
      OP_PROG: begin
        unique case (step_q)
          3'h0: seq_dat = UD1;
          3'h1: begin seq_a = UA2; seq_dat = UD2; end
          3'h2: seq_dat = CMD_PROG;
          default: begin
            seq_a    = addr_q;  // one word per program
            seq_dat  = wdat_q;
            seq_last = 1'b1;
          end
        endcase
      end
      OP_OTP: begin
        unique case (step_q)
          3'h0: seq_dat = UD1;
          3'h1: begin seq_a = UA2; seq_dat = UD2; end
          default: begin seq_dat = CMD_OTP; seq_last = 1'b1; end
        endcase
      end
      OP_ERASE: begin
        unique case (step_q)
          3'h0, 3'h3: seq_dat = UD1;
          3'h1, 3'h4: begin seq_a = UA2; seq_dat = UD2; end
          3'h2: seq_dat = CMD_ERASE;
          default: begin
            seq_a    = {addr_q[BLK_MSB:BLK_LSB], 12'h000};  // block erase
            seq_dat  = CMD_BERS;
            seq_last = 1'b1;
          end
        endcase
      end
    endcase
  end

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    step_d = step_q;
    op_d   = op_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    last_d = last_q;
    err_d  = err_q;
    otp_d  = otp_q;
    pins_d = pins_q;
    bus_d  = bus_q;
    // apb register writes
    if (acc_w) begin
      unique case (paddr)
        REG_ADDR:  if (!busy) addr_d = pwdata[20:0];
        REG_WDATA: if (!busy) wdat_d = pwdata[15:0];
        REG_PINS:  pins_d = pwdata[4:0];
        default: ;
      endcase
    end
    // otp window: ctrl writes with pwdata above OTP_CUST_HI flagged, not started; addr_q itself is not checked
    if (acc_w && paddr == REG_CTRL && !busy) begin
      op_d   = op_t'(pwdata[CTRL_OP_LSB +: CTRL_OP_W]);
      step_d = 3'h0;
      cnt_d  = SETUP_CYC;
      if (otp_q && pwdata[20:0] > OTP_CUST_HI) begin
        err_d = 1'b1;
      end else begin
        err_d = 1'b0;
        st_d  = S_SETUP;
        // id voltages follow the op, so a stale level never leaks into the next one
        pins_d[PIN_IDV_A9] = (op_d == OP_AUTOID);
        pins_d[PIN_IDV_RS] = (op_d == OP_PROT);
      end
    end
    unique case (st_q)
      S_IDLE: begin
        bus_d.ce_n    = 1'b1;   // standby between cycles
        bus_d.oe_n    = 1'b1;
        bus_d.we_n    = 1'b1;
        bus_d.dq_oe_n = 1'b1;
      end
      S_SETUP: begin
        bus_d.ce_n    = 1'b0;
        bus_d.addr    = seq_a;
        bus_d.dq_out  = seq_dat;
        bus_d.dq_oe_n = seq_rd;
        if (cnt_q == 4'h0) begin
          if (seq_rd) begin
            bus_d.oe_n = 1'b0;   // read: oe low, we high
            cnt_d      = ACC_CYC + 4'h2;  // plus synchroniser latency
            st_d       = S_RDWT;
          end else begin
            bus_d.we_n = 1'b0;   // write: oe high, we low
            cnt_d      = WP_CYC;
            st_d       = S_PULSE;
          end
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      S_PULSE: begin
        if (cnt_q == 4'h0) begin
          bus_d.we_n = 1'b1;   // device latches on we rise
          cnt_d      = SETUP_CYC;
          st_d       = S_GAP;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      S_RDWT: begin
        if (cnt_q == 4'h0) begin
          rdat_d     = dq_s2_q;
          bus_d.oe_n = 1'b1;
          bus_d.ce_n = 1'b1;
          st_d       = S_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      S_GAP: begin
        bus_d.ce_n    = 1'b1;
        bus_d.dq_oe_n = 1'b1;
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (!seq_last) begin
          step_d = step_q + 3'h1;
          cnt_d  = SETUP_CYC;
          st_d   = S_SETUP;
        end else if (op_q == OP_PROG || op_q == OP_ERASE) begin
          cnt_d = ACC_CYC + 4'h2;
          st_d  = S_POLL;
        end else begin
          if (op_q == OP_OTP) otp_d = 1'b1;
          if (op_q == OP_RESET) otp_d = 1'b0;
          st_d = S_IDLE;
        end
      end
      S_POLL: begin
        // busy until ready/busy rises and two status reads agree on dq6
        bus_d.ce_n = 1'b0;
        bus_d.oe_n = 1'b0;
        bus_d.addr = addr_q;
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          last_d = dq_s2_q;
          cnt_d  = ACC_CYC + 4'h2;
          if (rb_s2_q && last_q[6] == dq_s2_q[6]) begin
            rdat_d     = dq_s2_q;  // device back in array read
            bus_d.oe_n = 1'b1;
            bus_d.ce_n = 1'b1;
            st_d       = S_IDLE;
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
    // reset pin low aborts the device; host drops its sequence too
    if (!pins_q[PIN_RESET] && busy) begin
      st_d          = S_IDLE;
      err_d         = 1'b1;
      bus_d.ce_n    = 1'b1;  // release the bus at once, no half cycle left behind
      bus_d.oe_n    = 1'b1;
      bus_d.we_n    = 1'b1;
      bus_d.dq_oe_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, no unmapped error beyond slverr
  always_comb begin
    pready_d  = psel && penable && !pready;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (psel && penable && !pready) begin
      unique case (paddr)
        REG_CTRL:   prdata_d = {29'h0, op_q};
        REG_ADDR:   prdata_d = {11'h000, addr_q};
        REG_WDATA:  prdata_d = {16'h0000, wdat_q};
        REG_STATUS: prdata_d = {27'h0, otp_q, rdat_q[7], err_q, rb_s2_q, busy};
        REG_RDATA:  prdata_d = {16'h0000, rdat_q};
        REG_PINS:   prdata_d = {27'h0, pins_q};
        default:    pslverr_d = 1'b1;
      endcase
    end
    if (acc_r) ;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= S_IDLE;
      cnt_q   <= 4'h0;
      step_q  <= 3'h0;
      op_q    <= OP_READ;
      addr_q  <= 21'h000000;
      wdat_q  <= 16'h0000;
      rdat_q  <= 16'h0000;
      last_q  <= 16'h0000;
      err_q   <= 1'b0;
      otp_q   <= 1'b0;
      pins_q  <= 5'h11;
      bus_q   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 21'h000000,
                   dq_out: 16'h0000, dq_oe_n: 1'b1};
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      step_q  <= step_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      rdat_q  <= rdat_d;
      last_q  <= last_d;
      err_q   <= err_d;
      otp_q   <= otp_d;
      pins_q  <= pins_d;
      bus_q   <= bus_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // pin levels; accel overrides protect low at the device
  assign fbus = bus_q;
  always_comb begin
    fctl.prot_low   = pins_q[PIN_PROT];
    fctl.accel_high = pins_q[PIN_ACCEL];
    fctl.reset_idv  = pins_q[PIN_IDV_RS];
    fctl.a9_idv     = pins_q[PIN_IDV_A9];
    fctl.reset_n    = pins_q[PIN_RESET];
  end
endmodule : flash_host
`default_nettype wire

// >>> logic/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;
  // apb register offsets (byte addresses)
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_ADDR   = 12'h004;
  localparam logic [11:0] REG_WDATA  = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_RDATA  = 12'h010;
  localparam logic [11:0] REG_PINS   = 12'h014;
  // ctrl fields: writing ctrl starts an operation
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W   = 3;
  // pins fields
  localparam int PIN_PROT   = 0;
  localparam int PIN_ACCEL  = 1;
  localparam int PIN_IDV_RS = 2;
  localparam int PIN_IDV_A9 = 3;
  localparam int PIN_RESET  = 4;
  // status fields
  localparam int ST_BUSY  = 0;
  localparam int ST_RB    = 1;
  localparam int ST_ERR   = 2;
  localparam int ST_DPOLL = 3;
  // device geometry
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BLK_LSB = 12;
  localparam int BLK_MSB = 20;
  localparam int N_BLOCKS = 78;
  localparam int N_SMALL  = 16;
  localparam int N_LARGE  = 62;
  localparam logic [20:0] OTP_FACT_LO = 21'h000000;
  localparam logic [20:0] OTP_FACT_HI = 21'h00007F;
  localparam logic [20:0] OTP_CUST_LO = 21'h000080;
  localparam logic [20:0] OTP_CUST_HI = 21'h0000FF;
  // unlock command codes
  localparam logic [20:0] UA1 = 21'h000555;
  localparam logic [20:0] UA2 = 21'h0002AA;
  localparam logic [15:0] UD1 = 16'h00AA;
  localparam logic [15:0] UD2 = 16'h0055;
  localparam logic [15:0] CMD_PROG  = 16'h00A0;
  localparam logic [15:0] CMD_ERASE = 16'h0080;
  localparam logic [15:0] CMD_BERS  = 16'h0030;
  localparam logic [15:0] CMD_AUTO  = 16'h0090;
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_OTP   = 16'h0088;
  // bus timing in ns and derived cycle counts at 25 MHz
  localparam int CLK_NS      = 40;
  localparam int T_ACCESS_NS = 70;
  localparam int T_WPULSE_NS = 45;
  localparam logic [3:0] ACC_CYC = 4'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WP_CYC  = 4'((T_WPULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] SETUP_CYC = 4'h1;
  // operations
  typedef enum logic [2:0] {
    OP_READ   = 3'b000,
    OP_PROG   = 3'b001,
    OP_ERASE  = 3'b010,
    OP_AUTOID = 3'b011,
    OP_RESET  = 3'b100,
    OP_OTP    = 3'b101,
    OP_RAW_WR = 3'b110,
    OP_PROT   = 3'b111
  } op_t;
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
  } flash_bus_t;
  typedef struct packed {
    logic prot_low;
    logic accel_high;
    logic reset_idv;
    logic a9_idv;
    logic reset_n;
  } flash_ctl_t;
endpackage : flash_host_pkg
`default_nettype wire

// >>> tb/flash_dev.sv
`default_nettype none
module flash_dev
  import flash_host_pkg::*;
#(
  parameter logic [15:0] MID  = 16'h1A2B, // arbitrary value
  parameter logic [15:0] DID  = 16'h3C4D, // arbitrary value
  parameter int          BUSY = 4000
)(
  input  wire flash_host_pkg::flash_bus_t fbus,
  input  wire flash_host_pkg::flash_ctl_t fctl,
  output logic [15:0]                     dq,
  output logic                            rb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [int];
  logic [15:0] rdv = 16'hFFFF;
  logic [15:0] pd;
  logic        pe;
  logic        idm = 1'b0;
  logic        tog = 1'b0;
  int          pa;
  int          st = 0;
  initial rb = 1'b1;
  function automatic logic [15:0] rw(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : rw
  // outermost 4 Kword blocks at both ends
  function automatic logic guard(input int a);
    return fctl.prot_low && !fctl.accel_high && (a < 'h1000 || a >= 'h1FF000);
  endfunction : guard
  //////////////////////////////////////////
  // a released bus shows the inverse so stale data never passes
  assign dq = (!fbus.ce_n && !fbus.oe_n && fctl.reset_n) ? rdv : ~rdv;
  always @(negedge fbus.oe_n) begin
    tog = ~tog;
    if (!rb) rdv = {8'h00, ~pd[7], tog, 6'h00};
    else if (idm || fctl.a9_idv && !fbus.addr[6] && !fbus.addr[1])
      rdv = fbus.addr[0] ? DID : MID;
    else rdv = rw(int'(fbus.addr));
  end
  always @(posedge fbus.we_n) begin
    int a;
    logic [15:0] d;
    a = int'(fbus.addr);
    d = fbus.dq_out;
    if (fbus.ce_n === 1'b0 && fctl.reset_n && rb) begin
      if (d == 16'h00F0) begin
        st = 0;
        idm = 1'b0;
      end else case (st)
        0, 3: st = (a == 'h555 && d == 16'h00AA) ? st + 1 : 0;
        1, 4: st = (a == 'h2AA && d == 16'h0055) ? st + 1 : 0;
        2: begin
          st = (a != 'h555) ? 0 : (d == 16'h00A0) ? 6 : (d == 16'h0080) ? 3 : 0;
          idm = idm | (a == 'h555 && d == 16'h0090);
        end
        default: begin
          if (st == 6 || d == 16'h0030) begin
            pa = a;
            pe = (st == 5);
            pd = pe ? 16'hFFFF : d;
            if (!guard(a)) rb = 1'b0;
          end
          st = 0;
        end
      endcase
    end
  end
  always @(negedge rb) begin
    int sz;
    #(BUSY);
    if (!rb) begin
      // pre-program leaves nothing visible, the block ends all ones
      sz = (pa < 'h8000 || pa >= 'h1F8000) ? 'h1000 : 'h8000;
      if (pe) for (int k = pa - pa % sz; k < pa - pa % sz + sz; k++)
        if (mem.exists(k)) mem.delete(k);
      if (!pe) mem[pa] = rw(pa) & pd;
      rb = 1'b1;
    end
  end
  always @(negedge fctl.reset_n) begin
    rb = 1'b1;
    st = 0;
    idm = 1'b0;
  end
endmodule : flash_dev
`default_nettype wire

// >>> tb/flash_host_chk.sv
`default_nettype none
module flash_host_chk
  import flash_host_pkg::*;
(
  input wire logic                       mclk,
  input wire logic                       arst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic [11:0]                paddr,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire flash_host_pkg::flash_bus_t fbus,
  input wire flash_host_pkg::flash_ctl_t fctl
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_rd_pins;
    !fbus.oe_n |-> !fbus.ce_n && fbus.we_n && fbus.dq_oe_n;
  endproperty
  a_rd_pins: assert property (p_rd_pins)
    else $error("read cycle pins wrong");
  property p_wr_pins;
    !fbus.we_n |-> !fbus.ce_n && fbus.oe_n && !fbus.dq_oe_n;
  endproperty
  a_wr_pins: assert property (p_wr_pins)
    else $error("write cycle pins wrong");
  property p_we_len;
    // a reset pin abort may cut the pulse short
    disable iff (!arst_n || !fctl.reset_n)
    $fell(fbus.we_n) |-> !fbus.we_n [*3] ##1 fbus.we_n;
  endproperty
  a_we_len: assert property (p_we_len)
    else $error("write pulse length wrong");
  property p_wr_hold;
    !fbus.we_n |-> $stable(fbus.addr) && $stable(fbus.dq_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("address or data moved in write");
  property p_setup;
    $fell(fbus.we_n) |-> !$past(fbus.ce_n);
  endproperty
  a_setup: assert property (p_setup)
    else $error("no select before write");
  property p_ack;
    psel && penable && !pready |=> pready;
  endproperty
  a_ack: assert property (p_ack)
    else $error("apb answer late");
  property p_ack_pulse;
    pready |=> !pready;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("pready held");
  property p_no_req;
    !psel |=> !pready;
  endproperty
  a_no_req: assert property (p_no_req)
    else $error("pready without request");
  property p_slverr;
    pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > REG_PINS);
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("slave error wrong");
endmodule : flash_host_chk
bind flash_host flash_host_chk u_chk (.mclk, .arst_n, .psel, .penable, .paddr, .pready,
                                      .pslverr, .fbus, .fctl);
`default_nettype wire

// >>> tb/tb.sv
`default_nettype none
module tb
  import flash_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MID = 16'h1A2B; // arbitrary value
  localparam logic [15:0] DID = 16'h3C4D; // arbitrary value
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } row_t;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [15:0] dq;
  logic        pready, pslverr, rb, e, seen;
  flash_bus_t  fbus;
  flash_ctl_t  fctl;
  int          n_fail = 0;
  int          compares = 0;
  row_t        rows [7] = '{
    '{1'b0, REG_PINS, 32'h0, 32'h11, 1'b0}, '{1'b0, REG_STATUS, 32'h0, 32'h02, 1'b0},
    '{1'b1, REG_PINS, 32'h19, 32'h0, 1'b0}, '{1'b0, REG_PINS, 32'h0, 32'h19, 1'b0},
    '{1'b1, REG_PINS, 32'h11, 32'h0, 1'b0}, '{1'b0, 12'h018, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'hFFC, 32'h5, 32'h0, 1'b1}};
  flash_host dut (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                  .pready, .pslverr, .fbus, .fctl, .dq_in(dq), .ready_busy_output(rb));
  flash_dev #(.MID(MID), .DID(DID), .BUSY(4000)) u_dev (.fbus, .fctl, .dq, .rb);
  always #20 mclk = ~mclk;
  //////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // one idle edge after each transfer keeps drivers single per time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic op(input logic [2:0] c, input logic [20:0] a, input logic [15:0] d,
                    input logic ab = 1'b0);
    apb(1'b1, REG_ADDR, 32'(a));
    apb(1'b1, REG_WDATA, 32'(d));
    apb(1'b1, REG_CTRL, 32'(c));
    if (ab) apb(1'b1, REG_PINS, 32'h0);
    seen = 1'b0;
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      seen |= !r[ST_RB];
      if (!r[ST_BUSY]) break;
    end
  endtask : op
  task automatic rd(input logic [20:0] a);
    op(OP_READ, a, 16'h0);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask : rd
  task automatic cmd(input logic [15:0] d2, input logic [15:0] d3);
    op(OP_RAW_WR, 21'h000555, 16'h00AA);
    op(OP_RAW_WR, 21'h0002AA, d2);
    op(OP_RAW_WR, 21'h000555, d3);
  endtask : cmd
  //////////////////////////////////////////
  initial begin
    #2000000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk(32'(fctl), 32'h11);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(32'(e), 32'(rows[i].e));
      if (!rows[i].w && !rows[i].e) chk(r, rows[i].x);
    end
    op(OP_PROG, 21'h000800, 16'hA5A5);
    rd(21'h000800);
    chk(r, 32'hFFFF);
    apb(1'b1, REG_PINS, 32'h10);
    op(OP_PROG, 21'h000800, 16'h1234);
    chk(32'(seen), 32'h1);
    rd(21'h000800);
    chk(r, 32'h1234);
    op(OP_PROG, 21'h000C00, 16'h5555);
    op(OP_PROG, 21'h001000, 16'h0F0F);
    op(OP_PROG, 21'h00FFF0, 16'h00AA);
    op(OP_ERASE, 21'h000800, 16'h0);
    op(OP_ERASE, 21'h008000, 16'h0);
    rd(21'h000C00);
    chk(r, 32'hFFFF);
    rd(21'h00FFF0);
    chk(r, 32'hFFFF);
    rd(21'h001000);
    chk(r, 32'h0F0F);
    op(OP_AUTOID, 21'h000000, 16'h0);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(r, 32'(MID));
    op(OP_AUTOID, 21'h000001, 16'h0);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(r, 32'(DID));
    cmd(16'h0055, 16'h0090);
    rd(21'h000001);
    chk(r, 32'(DID));
    op(OP_RESET, 21'h000000, 16'h0);
    op(OP_PROT, 21'h000002, 16'h0000);
    chk(32'(fctl.reset_idv), 32'h1);
    op(OP_OTP, 21'h000000, 16'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(r[4]), 32'h1);
    apb(1'b1, REG_CTRL, 32'h100);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(r[ST_ERR]), 32'h1);
    op(OP_RESET, 21'h000000, 16'h0);
    chk(32'(r[4]), 32'h0);
    cmd(16'h0077, 16'h00A0);
    op(OP_RAW_WR, 21'h001000, 16'h0000);
    rd(21'h001000);
    chk(r, 32'h0F0F);
    op(OP_PROG, 21'h001000, 16'h0000, 1'b1);
    chk(32'(r[ST_ERR]), 32'h1);
    apb(1'b1, REG_PINS, 32'h10);
    rd(21'h001000);
    chk(r, 32'h0F0F);
    stop_test();
  end
endmodule : tb
`default_nettype wire
